// [pkg/uss_pkg.sv]
// Package holding the register map, field positions and state record of the sync slave port.
package uss_pkg;

  // ******************************
  // Register byte offsets
  // ******************************
  localparam logic [7:0] OFF_FLAGS = 8'h00;
  localparam logic [7:0] OFF_ENABLES = 8'h04;
  localparam logic [7:0] OFF_PRIORITY = 8'h08;
  localparam logic [7:0] OFF_RXCTL = 8'h0C;
  localparam logic [7:0] OFF_TXBUF = 8'h10;
  localparam logic [7:0] OFF_TXCTL = 8'h14;
  localparam logic [7:0] OFF_RATE = 8'h18;
  localparam logic [7:0] OFF_RXBUF = 8'h1C;
  localparam logic [7:0] OFF_EVENTS = 8'h20;

  // ******************************
  // Field positions
  // ******************************
  // Flag, enable and event registers share one layout.
  localparam int B_RXFULL = 5;
  localparam int B_TXEMPTY = 4;
  // Transmit status and control.
  localparam int B_CLK_SRC = 7;
  localparam int B_NINE_TX = 6;
  localparam int B_TXON = 5;
  localparam int B_SYNC = 4;
  localparam int B_BRGH = 2;
  localparam int B_SHIFT_EMPTY = 1;
  localparam int B_NINTH_TX = 0;
  // Receive status and control.
  localparam int B_PORT_ON = 7;
  localparam int B_NINE_RX = 6;
  localparam int B_ONE_RX = 5;
  localparam int B_CONT_RX = 4;
  localparam int B_ADDEN = 3;
  localparam int B_FRAME_ERR = 2;
  localparam int B_OVERRUN = 1;
  localparam int B_NINTH_RX = 0;

  // ******************************
  // Reset values
  // ******************************
  localparam logic [7:0] RST_TXCTL = 8'h02;
  localparam logic [7:0] RST_PRIORITY = 8'hFF;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // Word lengths in bits.
  localparam logic [3:0] LEN_8 = 4'h8;
  localparam logic [3:0] LEN_9 = 4'h9;

  // Whole state of the block.
  typedef struct packed {
    logic [7:0] ie;
    logic [7:0] ip;
    logic [7:0] rate;
    logic [7:0] evt;
    logic [7:0] txbuf;
    logic txfull;
    logic txempty;
    logic [7:0] txctl;
    logic [7:0] rxctl;
    logic [7:0] rxbuf;
    logic rxfull;
    logic [8:0] tsh;
    logic [3:0] tcnt;
    logic [3:0] tlen;
    logic dout;
    logic [8:0] rsh;
    logic [3:0] rcnt;
    logic ck1;
    logic ck2;
    logic ck3;
    logic d1;
    logic d2;
    logic [31:0] prdata;
  } uss_state_t;

endpackage

// [design/uss_top.sv]
// Synchronous slave serial port with APB registers, clocked from an external shift clock pin.
//
// What this block does
// - With clock source select clear in sync mode the shift clock comes only from the clock pin.
// - Shifting continues under the external clock while the core sleeps.
// - With two words written, the first moves to the shifter at once; the flag sets on that move and clears on the second write, its event bit staying set.
// - When the first word is out, the second moves to the shifter and the empty flag sets.
// - The empty event bit, set along with the flag, and its enable raise the interrupt that wakes the sleeping core.
// - Single receive enable is ignored; receive otherwise works as in master mode.
// - With continuous receive on, a word completes during sleep and wakes the core when the receive full enable is set.
// - A completed word sets the receive full flag and interrupts when enabled.
// - Ninth bit and errors sit in receive status, data in the receive buffer; status is read first.
// - Clearing continuous receive clears a pending receive error.
// - Transmit status reset value has only the shifter empty bit set; bit 3 reads zero.
// - The empty flag sets on transfer to the shifter and clears only on a buffer write.
// - A read-only shifter empty bit shows an idle shifter and has no interrupt.
// - Receive data is sampled at the falling edge of the shift clock.
// - Transmit and receive never run at the same time.
`timescale 1ns/1ps
module uss_top #(
  parameter int AW = 8
) (
  // APB slave.
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [AW-1:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins.
  input logic shift_clock_pin_i,
  input logic serial_data_pin_i,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe_n,
  // Core power state and interrupt.
  input logic core_sleep,
  output logic irq,
  output logic wake
);

  // ******************************
  // State and decode
  // ******************************
  uss_pkg::uss_state_t s_r;
  uss_pkg::uss_state_t s_nxt;
  logic setup;
  logic wr;
  logic rd;
  logic hit;
  logic [7:0] a8;
  logic link_on;
  logic rise;
  logic fall;
  logic tx_en;
  logic rx_en;
  logic tx_busy;
  logic load;
  logic rx_done;
  logic [8:0] rnew;
  logic [7:0] rdat;
  logic r9;
  logic [7:0] flags;

  // Bus phases; writes take effect in the access phase.
  assign a8 = 8'(paddr);
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign hit = (a8 <= uss_pkg::OFF_EVENTS) & (a8[1:0] == 2'h0);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = s_r.prdata;

  // Edges come from the second and third flops only.
  assign rise = s_r.ck2 & ~s_r.ck3;
  assign fall = ~s_r.ck2 & s_r.ck3;

  // external clock only
  // The link listens only in sync slave mode, so the pin never clocks master mode.
  assign link_on = s_r.rxctl[uss_pkg::B_PORT_ON] & s_r.txctl[uss_pkg::B_SYNC] & ~s_r.txctl[uss_pkg::B_CLK_SRC];

  // half duplex gating
  // Continuous receive wins; transmit waits until receive is cleared.
  assign tx_en = link_on & s_r.txctl[uss_pkg::B_TXON] & ~s_r.rxctl[uss_pkg::B_CONT_RX];
  assign rx_en = link_on & s_r.rxctl[uss_pkg::B_CONT_RX] & ~s_r.rxctl[uss_pkg::B_OVERRUN];
  assign tx_busy = ~s_r.txctl[uss_pkg::B_SHIFT_EMPTY];

  // immediate shifter load
  // A load waits one cycle past a buffer write so the write never races it.
  assign load = tx_en & ~tx_busy & s_r.txfull & ~(wr & (a8 == uss_pkg::OFF_TXBUF));

  assign rnew = {s_r.d2, s_r.rsh[8:1]};
  assign rx_done = rx_en & fall & ((s_r.rcnt + 4'h1) == (s_r.rxctl[uss_pkg::B_NINE_RX] ? uss_pkg::LEN_9 : uss_pkg::LEN_8));
  assign rdat = s_r.rxctl[uss_pkg::B_NINE_RX] ? rnew[7:0] : rnew[8:1];
  assign r9 = s_r.rxctl[uss_pkg::B_NINE_RX] & rnew[8];

  // Live flag register view.
  always_comb begin
    flags = 8'h00;
    flags[uss_pkg::B_RXFULL] = s_r.rxfull;
    flags[uss_pkg::B_TXEMPTY] = s_r.txempty;
  end

  // ******************************
  // Interrupt and pins
  // ******************************
  // interrupt and wake
  // The interrupt is a level; wake is the same level qualified by sleep.
  assign irq = |(s_r.evt & s_r.ie);
  assign wake = irq & core_sleep;
  assign serial_data_pin_o = s_r.dout;
  assign serial_data_pin_oe_n = ~(tx_en & tx_busy);

  // ******************************
  // Next state
  // ******************************
  // One process computes the whole next state.
  always_comb begin
    s_nxt = s_r;
    // Synchronisers: first flop feeds only the second.
    s_nxt.ck1 = shift_clock_pin_i;
    s_nxt.ck2 = s_r.ck1;
    s_nxt.ck3 = s_r.ck2;
    s_nxt.d1 = serial_data_pin_i;
    s_nxt.d2 = s_r.d1;

    // Register writes.
    if (wr) begin
      case (a8)
        uss_pkg::OFF_ENABLES: begin
          s_nxt.ie = pwdata[7:0];
        end
        uss_pkg::OFF_PRIORITY: begin
          s_nxt.ip = pwdata[7:0];
        end
        uss_pkg::OFF_RATE: begin
          s_nxt.rate = pwdata[7:0];
        end
        uss_pkg::OFF_TXBUF: begin
          s_nxt.txbuf = pwdata[7:0];
          s_nxt.txfull = 1'b1;
          s_nxt.txempty = 1'b0;
        end
        uss_pkg::OFF_TXCTL: begin
          s_nxt.txctl[uss_pkg::B_CLK_SRC] = pwdata[uss_pkg::B_CLK_SRC];
          s_nxt.txctl[uss_pkg::B_NINE_TX] = pwdata[uss_pkg::B_NINE_TX];
          s_nxt.txctl[uss_pkg::B_TXON] = pwdata[uss_pkg::B_TXON];
          s_nxt.txctl[uss_pkg::B_SYNC] = pwdata[uss_pkg::B_SYNC];
          s_nxt.txctl[uss_pkg::B_BRGH] = pwdata[uss_pkg::B_BRGH];
          s_nxt.txctl[uss_pkg::B_NINTH_TX] = pwdata[uss_pkg::B_NINTH_TX];
        end
        uss_pkg::OFF_RXCTL: begin
          s_nxt.rxctl[uss_pkg::B_PORT_ON] = pwdata[uss_pkg::B_PORT_ON];
          s_nxt.rxctl[uss_pkg::B_NINE_RX] = pwdata[uss_pkg::B_NINE_RX];
          s_nxt.rxctl[uss_pkg::B_ONE_RX] = pwdata[uss_pkg::B_ONE_RX];
          s_nxt.rxctl[uss_pkg::B_CONT_RX] = pwdata[uss_pkg::B_CONT_RX];
          s_nxt.rxctl[uss_pkg::B_ADDEN] = pwdata[uss_pkg::B_ADDEN];
        end
        uss_pkg::OFF_EVENTS: begin
          s_nxt.evt = s_r.evt & ~pwdata[7:0];
        end
        default: begin
        end
      endcase
    end

    // error cleared with receive
    // Dropping continuous receive also abandons any half word.
    if (~s_nxt.rxctl[uss_pkg::B_CONT_RX]) begin
      s_nxt.rxctl[uss_pkg::B_OVERRUN] = 1'b0;
      s_nxt.rcnt = 4'h0;
    end

    if (rd & (a8 == uss_pkg::OFF_RXBUF)) begin
      s_nxt.rxfull = 1'b0;
    end

    // Transmit shifting; an aborted transfer leaves the shifter empty.
    if (~tx_en) begin
      s_nxt.txctl[uss_pkg::B_SHIFT_EMPTY] = 1'b1;
      s_nxt.tcnt = 4'h0;
    end else if (tx_busy & rise) begin
      s_nxt.dout = s_r.tsh[0];
      s_nxt.tsh = {1'b0, s_r.tsh[8:1]};
      s_nxt.tcnt = s_r.tcnt + 4'h1;
    end else if (tx_busy & fall & (s_r.tcnt == s_r.tlen)) begin
      s_nxt.txctl[uss_pkg::B_SHIFT_EMPTY] = 1'b1;
      s_nxt.tcnt = 4'h0;
    end

    // reload then flag
    // The flag sets in the same cycle that the buffer empties into the shifter.
    if (load) begin
      s_nxt.tsh = {s_r.txctl[uss_pkg::B_NINTH_TX], s_r.txbuf};
      s_nxt.tlen = s_r.txctl[uss_pkg::B_NINE_TX] ? uss_pkg::LEN_9 : uss_pkg::LEN_8;
      s_nxt.tcnt = 4'h0;
      s_nxt.txctl[uss_pkg::B_SHIFT_EMPTY] = 1'b0;
      s_nxt.txfull = 1'b0;
      s_nxt.txempty = 1'b1;
      s_nxt.evt[uss_pkg::B_TXEMPTY] = 1'b1;
    end

    // receive runs during sleep
    // Nothing here looks at core_sleep, so sleep never stalls the shifters.
    if (rx_en & fall) begin
      s_nxt.rsh = rnew;
      s_nxt.rcnt = rx_done ? 4'h0 : s_r.rcnt + 4'h1;
    end

    // word complete
    // A word landing on an unread buffer is lost and reception halts until cleared.
    if (rx_done) begin
      if (s_r.rxfull) begin
        s_nxt.rxctl[uss_pkg::B_OVERRUN] = 1'b1;
      end else begin
        s_nxt.rxbuf = rdat;
        s_nxt.rxctl[uss_pkg::B_NINTH_RX] = r9;
        s_nxt.rxfull = 1'b1;
        s_nxt.evt[uss_pkg::B_RXFULL] = 1'b1;
      end
    end

    // Read data is captured in setup so the access phase needs no wait.
    if (setup) begin
      s_nxt.prdata = 32'h0000_0000;
      case (a8)
        uss_pkg::OFF_FLAGS: s_nxt.prdata[7:0] = flags;
        uss_pkg::OFF_ENABLES: s_nxt.prdata[7:0] = s_r.ie;
        uss_pkg::OFF_PRIORITY: s_nxt.prdata[7:0] = s_r.ip;
        uss_pkg::OFF_RXCTL: s_nxt.prdata[7:0] = s_r.rxctl;
        uss_pkg::OFF_TXBUF: s_nxt.prdata[7:0] = s_r.txbuf;
        uss_pkg::OFF_TXCTL: s_nxt.prdata[7:0] = s_r.txctl;
        uss_pkg::OFF_RATE: s_nxt.prdata[7:0] = s_r.rate;
        uss_pkg::OFF_RXBUF: s_nxt.prdata[7:0] = s_r.rxbuf;
        uss_pkg::OFF_EVENTS: s_nxt.prdata[7:0] = s_r.evt;
        default: s_nxt.prdata = 32'h0000_0000;
      endcase
    end
  end

  // ******************************
  // State register
  // ******************************
  // transmit control reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.txctl <= uss_pkg::RST_TXCTL;
      s_r.ip <= uss_pkg::RST_PRIORITY;
      s_r.rxctl <= uss_pkg::RST_ZERO;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ******************************
  // Assertions
  // ******************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  load_empty_a: assert property (load |=> tx_busy && !s_r.txfull && s_r.txempty)
    else $error("shifter load did not empty buffer");
  flag_clear_a: assert property (wr && a8 == uss_pkg::OFF_TXBUF |=> !s_r.txempty && s_r.txfull)
    else $error("buffer write did not clear empty flag");
  rx_full_a: assert property (rx_done && !s_r.rxfull |=> s_r.rxfull && s_r.rxbuf == $past(rdat))
    else $error("completed word not stored");
  wake_irq_a: assert property (load && s_r.ie[uss_pkg::B_TXEMPTY] && core_sleep |=> irq && wake)
    else $error("empty flag did not wake core");
  err_clear_a: assert property (!s_r.rxctl[uss_pkg::B_CONT_RX] |-> !s_r.rxctl[uss_pkg::B_OVERRUN])
    else $error("error pending with receive off");
  fall_count_a: assert property (rx_en && fall && !rx_done |=> s_r.rcnt == $past(s_r.rcnt) + 4'h1)
    else $error("falling edge not sampled");
  half_duplex_a: assert property (!serial_data_pin_oe_n |-> !rx_en)
    else $error("transmit and receive both active");
  rise_drive_a: assert property (tx_en && tx_busy && rise |=> s_r.dout == $past(s_r.tsh[0]))
    else $error("bit not driven after rising edge");
  empty_ro_a: assert property (wr && a8 == uss_pkg::OFF_TXCTL && !tx_en |=> s_r.txctl[uss_pkg::B_SHIFT_EMPTY])
    else $error("shifter empty bit disturbed");

  tx_word_c: cover property (load ##[1:1000] s_r.txctl[uss_pkg::B_SHIFT_EMPTY]);
  rx_word_c: cover property (rx_done && !s_r.rxfull);
  overrun_c: cover property (rx_done && s_r.rxfull);
  sleep_wake_c: cover property (core_sleep && wake);

endmodule // uss_top

// [tb/uss_master_model.sv]
// External synchronous master that makes the shift clock and shares the data pin.
`timescale 1ns/1ps
module uss_master_model (
  // Link pins.
  output logic sck,
  output logic dout,
  input wire logic din
);
  // The clock rests low between frames, and released data shows its inverse so stale bits never look valid.
  initial begin
    sck = 1'b0;
    dout = 1'b1;
  end

  // drive on rise, sample on fall
  task automatic frame(input logic [8:0] tx, input int n, output logic [8:0] rx);
    rx = 9'h000;
    #13;
    for (int i = 0; i < n; i++) begin
      sck = 1'b1;
      dout = tx[i];
      #100;
      sck = 1'b0;
      rx[i] = din;
      #100;
    end
    dout = ~dout;
  endtask
endmodule // uss_master_model

// [tb/usart_sync_slave_tb.sv]
// Self-checking bench for the synchronous slave serial port.
`timescale 1ns/1ps
module usart_sync_slave_tb;
  logic pclk, presetn, psel, penable, pwrite, core_sleep;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, sdo, oe_n, irq, wake, sck, mdo, dt, err;
  logic [8:0] rx;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;

  // The port wins the data pin while it drives, else the master's level shows.
  assign dt = oe_n ? mdo : sdo;

  uss_top #(.AW(8)) uss_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .shift_clock_pin_i(sck), .serial_data_pin_i(dt), .serial_data_pin_o(sdo),
    .serial_data_pin_oe_n(oe_n), .core_sleep(core_sleep), .irq(irq), .wake(wake));
  uss_master_model uss_master_model_i (.sck(sck), .dout(mdo), .din(dt));

  // Bus clock.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // A hang is cut short well after the expected run of about 500 cycles.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(rd, exp);
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    core_sleep = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(uss_pkg::OFF_TXCTL, 32'h00000002);
    rdchk(uss_pkg::OFF_PRIORITY, 32'h000000FF);
    rdchk(uss_pkg::OFF_RXCTL, 32'h00000000);
    rdchk(uss_pkg::OFF_FLAGS, 32'h00000000);
    apb(1'b0, 8'h24, 32'h00000000);
    check({rd[30:0], err}, 32'h00000001);
    $display("Test reset values done");
    apb(1'b1, uss_pkg::OFF_RXCTL, 32'h00000080);
    apb(1'b1, uss_pkg::OFF_ENABLES, 32'h00000010);
    apb(1'b1, uss_pkg::OFF_TXCTL, 32'h00000071);
    core_sleep <= 1'b1;
    apb(1'b1, uss_pkg::OFF_TXBUF, 32'h000000A5);
    apb(1'b1, uss_pkg::OFF_TXBUF, 32'h0000003C);
    rdchk(uss_pkg::OFF_FLAGS, 32'h00000000);
    rdchk(uss_pkg::OFF_TXCTL, 32'h00000071);
    apb(1'b1, uss_pkg::OFF_EVENTS, 32'h00000010);
    @(posedge pclk);
    check({31'h0, irq}, 32'h00000000);
    uss_master_model_i.frame(9'h000, 9, rx);
    check({23'h0, rx}, 32'h000001A5);
    repeat (4) @(posedge pclk);
    check({30'h0, irq, wake}, 32'h00000003);
    apb(1'b1, uss_pkg::OFF_FLAGS, 32'h00000000);
    rdchk(uss_pkg::OFF_FLAGS, 32'h00000010);
    uss_master_model_i.frame(9'h000, 9, rx);
    check({23'h0, rx}, 32'h0000013C);
    repeat (4) @(posedge pclk);
    rdchk(uss_pkg::OFF_TXCTL, 32'h00000073);
    check({31'h0, oe_n}, 32'h00000001);
    apb(1'b1, uss_pkg::OFF_EVENTS, 32'h00000010);
    $display("Test slave transmit done");
    apb(1'b1, uss_pkg::OFF_TXCTL, 32'h00000010);
    apb(1'b1, uss_pkg::OFF_ENABLES, 32'h00000000);
    apb(1'b1, uss_pkg::OFF_RXCTL, 32'h000000F0);
    uss_master_model_i.frame(9'h1C3, 9, rx);
    repeat (4) @(posedge pclk);
    check({30'h0, irq, oe_n}, 32'h00000001);
    apb(1'b1, uss_pkg::OFF_ENABLES, 32'h00000020);
    @(posedge pclk);
    check({30'h0, irq, wake}, 32'h00000003);
    // The empty flag stays set from the transmit test: only a buffer write clears it.
    rdchk(uss_pkg::OFF_FLAGS, 32'h00000030);
    rdchk(uss_pkg::OFF_RXCTL, 32'h000000F1);
    rdchk(uss_pkg::OFF_RXBUF, 32'h000000C3);
    rdchk(uss_pkg::OFF_FLAGS, 32'h00000010);
    uss_master_model_i.frame(9'h055, 9, rx);
    uss_master_model_i.frame(9'h0AA, 9, rx);
    repeat (4) @(posedge pclk);
    rdchk(uss_pkg::OFF_RXCTL, 32'h000000F2);
    rdchk(uss_pkg::OFF_RXBUF, 32'h00000055);
    apb(1'b1, uss_pkg::OFF_RXCTL, 32'h00000080);
    rdchk(uss_pkg::OFF_RXCTL, 32'h00000080);
    apb(1'b1, uss_pkg::OFF_EVENTS, 32'h00000020);
    @(posedge pclk);
    check({31'h0, irq}, 32'h00000000);
    $display("Test slave receive done");
    conclude();
  end
endmodule // usart_sync_slave_tb
